/* File: verilog/port_io_defs.vh */
// register map, field positions and reset values of the two i/o ports
`ifndef PORT_IO_DEFS_VH
`define PORT_IO_DEFS_VH

// register byte offsets
`define OFS_PAR_PINS 8'h00
`define OFS_PAR_LATCH 8'h04
`define OFS_PAR_DIR 8'h08
`define OFS_SLV_CTRL 8'h0c
`define OFS_SMALL_PINS 8'h10
`define OFS_SMALL_LATCH 8'h14
`define OFS_PWM_CTRL 8'h18
`define OFS_ANALOG_CFG 8'h1c

// reset values
`define RST_PAR_LATCH 8'h00
`define RST_PAR_DIR 8'hff
`define RST_SLV_CTRL 8'h07
`define RST_SMALL_LATCH 3'h0
`define RST_PWM_CTRL 8'h00
`define RST_ANALOG_CFG 4'h0

// slave control register fields
`define SLV_IN_FULL 7
`define SLV_OUT_FULL 6
`define SLV_OVERFLOW 5
`define SLV_MODE_SEL 4
`define SLV_DIR_MSB 2

// pwm control fields
`define PWM_OUT_MODE_MSB 7
`define PWM_OUT_MODE_LSB 6
`define PWM_CCP_MSB 3
`define PWM_CCP_LSB 2
`define PWM_CCP_IS_PWM 2'h3
`define PWM_OUT_SINGLE 2'h0
`define PWM_OUT_DUAL 2'h2

// analog config: small port pin n is digital from this code minus n
`define ANALOG_DIG_BASE 4'ha

// index of the fourth, input-only small port pin
`define SMALL_IN_ONLY 3

`endif

/* File: verilog/sync_two_stage.v */
// two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/1ps
module sync_two_stage #(
    parameter W = 14
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // levels
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg stable_q;
            // first stage is read only by the second
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    stable_q <= meta_q;
                end
            end
            assign sync_out[i] = stable_q;
        end
    endgenerate

endmodule

/* File: verilog/port_io.v */
// eight-bit and four-bit general purpose i/o ports with apb registers
//
// Overview of operation
// RQ1 - direction bit 1 floats a parallel pin; 0 drives its latch bit
// RQ2 - parallel latch register reads and writes the latch, not the pins
// RQ3 - each of the eight parallel pins has its own direction bit
// RQ4 - parallel bits 5 to 7 can carry the three extra pwm outputs
// RQ5 - after reset every parallel direction bit is one (all inputs)
// RQ6 - mode select bit 4 of slave control turns port into slave port
// RQ7 - dual or quad pwm output forces slave port mode off
// RQ8 - variants without the small port read its pins register as zero
// RQ9 - small port has four bits; analog-selected pins read as zero
// RQ10 - small port direction bits drive pins even in analog use
// RQ11 - after reset the three small port pins are analog inputs
// RQ12 - slave control upper nibble is slave status; low three are directions
// RQ13 - small port latch register reads and writes the latch, not pins
// RQ14 - config bit makes fourth pin a plain input (0) or master clear
// RQ15 - fourth pin reads as digital input only with master clear off
// RQ16 - mode select 1 means slave port, 0 means general purpose i/o
// RQ17 - software sets control pins as inputs and analog config to 1010
// RQ18 - pins register reads sampled pins; writing it updates the latch
`timescale 1ns/1ps
`include "port_io_defs.vh"
module port_io (
    // clock and reset
    input wire MCLK,
    input wire RESET_N,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // parallel port pins
    input wire [7:0] PAR_IN,
    output reg [7:0] PAR_OUT,
    output reg [7:0] PAR_OE,
    // small port pins, bit 3 is the input-only fourth pin
    input wire [3:0] SMALL_IN,
    output reg [2:0] SMALL_OUT,
    output reg [2:0] SMALL_OE,
    // configuration straps
    input wire MASTER_CLEAR_ENABLE_CFG,
    input wire SMALL_PORT_PRESENT,
    // pwm generator, same clock
    input wire PWM_OUT_B,
    input wire PWM_OUT_C,
    input wire PWM_OUT_D,
    // slave port handshake block, same clock
    input wire IN_BUFFER_FULL,
    input wire OUT_BUFFER_FULL,
    input wire IN_OVERFLOW_SET,
    output reg SLAVE_PORT_ACTIVE,
    // master clear request to the reset logic
    output reg MASTER_CLEAR_REQ
);

    // reset image of slave control, bit-selected for its fields
    localparam [7:0] slv_rst = `RST_SLV_CTRL;

    // register state
    reg [7:0] par_latch_q;
    reg [7:0] par_dir_q;
    reg overflow_q;
    reg mode_sel_q;
    reg [2:0] small_dir_q;
    reg [2:0] small_latch_q;
    reg [7:0] pwm_ctrl_q;
    reg [3:0] analog_cfg_q;

    // synchronised pins and straps
    wire [13:0] sync_bus;
    wire [7:0] par_pins;
    wire [3:0] small_pins;
    wire mclr_en;
    wire small_present;

    sync_two_stage #(
        .W(14)
    ) u_sync (
        .clk(MCLK),
        .rst_n(RESET_N),
        .async_in({SMALL_PORT_PRESENT, MASTER_CLEAR_ENABLE_CFG,
                   SMALL_IN, PAR_IN}),
        .sync_out(sync_bus)
    );

    assign par_pins = sync_bus[7:0];
    assign small_pins = sync_bus[11:8];
    assign mclr_en = sync_bus[12];
    assign small_present = sync_bus[13];

    // analog select of small pin n from the analog config code
    function is_analog;
        input [3:0] cfg;
        input [1:0] idx;
        begin
            is_analog = cfg < (`ANALOG_DIG_BASE - {2'h0, idx});
        end
    endfunction

    // address decode for the error flag, which also blocks writes
    function is_mapped;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_PAR_PINS, `OFS_PAR_LATCH, `OFS_PAR_DIR,
                `OFS_SLV_CTRL, `OFS_SMALL_PINS, `OFS_SMALL_LATCH,
                `OFS_PWM_CTRL, `OFS_ANALOG_CFG: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // pwm output steering
    wire [1:0] pwm_out_mode;
    wire pwm_running;
    wire pwm_multi;
    wire pwm_quad;
    assign pwm_out_mode = pwm_ctrl_q[`PWM_OUT_MODE_MSB:`PWM_OUT_MODE_LSB];
    assign pwm_running =
        pwm_ctrl_q[`PWM_CCP_MSB:`PWM_CCP_LSB] == `PWM_CCP_IS_PWM;
    assign pwm_multi = pwm_running && pwm_out_mode != `PWM_OUT_SINGLE;
    assign pwm_quad = pwm_multi && pwm_out_mode != `PWM_OUT_DUAL;

    // slave port only when not overridden by multi-output pwm
    wire slave_on;
    assign slave_on = mode_sel_q && !pwm_multi; // RQ6 RQ7 RQ16

    // per-pin analog selection of the three small pins
    wire [2:0] small_analog;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_an
            localparam [1:0] pin_idx = g;
            assign small_analog[g] = is_analog(analog_cfg_q, pin_idx);
        end
    endgenerate

    // pin readback values
    wire [7:0] small_read;
    wire fourth_pin;
    // fourth pin is only a port bit while master clear is disabled
    assign fourth_pin = !mclr_en && small_pins[`SMALL_IN_ONLY]; // RQ14 RQ15
    assign small_read = small_present ?
        {4'h0, fourth_pin, small_pins[2:0] & ~small_analog} : // RQ9
        8'h00; // RQ8

    // slave control readback: status nibble over direction bits
    wire [7:0] slv_read;
    assign slv_read = {IN_BUFFER_FULL, OUT_BUFFER_FULL, overflow_q,
                       mode_sel_q, 1'b0, small_dir_q}; // RQ12

    // read mux
    reg [7:0] rd_mux;
    always @* begin
        case (PADDR)
            `OFS_PAR_PINS: rd_mux = par_pins; // RQ18
            `OFS_PAR_LATCH: rd_mux = par_latch_q; // RQ2
            `OFS_PAR_DIR: rd_mux = par_dir_q;
            `OFS_SLV_CTRL: rd_mux = slv_read;
            `OFS_SMALL_PINS: rd_mux = small_read;
            `OFS_SMALL_LATCH: rd_mux = {5'h00, small_latch_q}; // RQ13
            `OFS_PWM_CTRL: rd_mux = pwm_ctrl_q;
            `OFS_ANALOG_CFG: rd_mux = {4'h0, analog_cfg_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // apb phases: answer is registered in setup, so one access cycle
    wire setup_ph;
    wire wr_take;
    assign setup_ph = PSEL && !PENABLE;
    assign wr_take = PSEL && PENABLE && PREADY && PWRITE;

    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else if (setup_ph) begin
            PREADY <= 1'b1;
            PSLVERR <= !is_mapped(PADDR);
            PRDATA <= PWRITE ? 32'h00000000 : {24'h000000, rd_mux};
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end
    end

    // register writes, taken at the completing access edge
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            par_latch_q <= `RST_PAR_LATCH;
            par_dir_q <= `RST_PAR_DIR; // RQ5
            mode_sel_q <= slv_rst[`SLV_MODE_SEL];
            small_dir_q <= slv_rst[`SLV_DIR_MSB:0];
            small_latch_q <= `RST_SMALL_LATCH;
            pwm_ctrl_q <= `RST_PWM_CTRL;
            analog_cfg_q <= `RST_ANALOG_CFG; // RQ11
        end else if (wr_take && !PSLVERR) begin
            case (PADDR)
                // both pins and latch writes land in the latch
                `OFS_PAR_PINS: par_latch_q <= PWDATA[7:0]; // RQ18
                `OFS_PAR_LATCH: par_latch_q <= PWDATA[7:0]; // RQ2
                `OFS_PAR_DIR: par_dir_q <= PWDATA[7:0]; // RQ3
                `OFS_SLV_CTRL: begin
                    mode_sel_q <= PWDATA[`SLV_MODE_SEL];
                    small_dir_q <= PWDATA[`SLV_DIR_MSB:0];
                end
                `OFS_SMALL_PINS: small_latch_q <= PWDATA[2:0];
                `OFS_SMALL_LATCH: small_latch_q <= PWDATA[2:0]; // RQ13
                `OFS_PWM_CTRL: pwm_ctrl_q <= PWDATA[7:0];
                `OFS_ANALOG_CFG: analog_cfg_q <= PWDATA[3:0];
                default: par_latch_q <= par_latch_q;
            endcase
        end
    end

    // overflow flag: set from slave port wins over a software clear
    wire ovf_write;
    assign ovf_write = wr_take && PADDR == `OFS_SLV_CTRL;
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            overflow_q <= slv_rst[`SLV_OVERFLOW];
        end else if (IN_OVERFLOW_SET) begin
            overflow_q <= 1'b1;
        end else if (ovf_write) begin
            overflow_q <= PWDATA[`SLV_OVERFLOW];
        end
    end

    // parallel pin data: pwm b replaces bit 5 in dual or quad, c and d replace bits 6 and 7 in quad only
    reg [7:0] par_data;
    always @* begin
        par_data = par_latch_q;
        if (pwm_multi) begin
            par_data[5] = PWM_OUT_B; // RQ4
        end
        if (pwm_quad) begin
            par_data[6] = PWM_OUT_C; // RQ4
            par_data[7] = PWM_OUT_D; // RQ4
        end
    end

    // pin drivers; in slave mode the handshake block owns the data pins
    // and the control pins stay inputs, so the port lets go of both
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PAR_OUT <= 8'h00;
            PAR_OE <= 8'h00;
            SMALL_OUT <= 3'h0;
            SMALL_OE <= 3'h0;
            SLAVE_PORT_ACTIVE <= 1'b0;
            MASTER_CLEAR_REQ <= 1'b0;
        end else begin
            PAR_OUT <= par_data;
            PAR_OE <= slave_on ? 8'h00 : ~par_dir_q; // RQ1 RQ3
            SMALL_OUT <= small_latch_q;
            // direction still rules while analog; software keeps inputs
            SMALL_OE <= (slave_on || !small_present) ?
                3'h0 : ~small_dir_q; // RQ10
            SLAVE_PORT_ACTIVE <= slave_on; // RQ6 RQ7
            // fourth pin as active-low master clear when enabled
            MASTER_CLEAR_REQ <= mclr_en &&
                !small_pins[`SMALL_IN_ONLY]; // RQ14
        end
    end

endmodule

/* File: dv/port_io_assertions.sv */
// concurrent checks on the apb answers, parallel pin outputs and master clear
`timescale 1ns/1ps
module port_io_assertions (
    // clock, reset and apb
    input wire MCLK,
    input wire RESET_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    // port side
    input wire [7:0] PAR_OUT,
    input wire [7:0] PAR_OE,
    input wire SLAVE_PORT_ACTIVE,
    input wire MASTER_CLEAR_ENABLE_CFG,
    input wire MASTER_CLEAR_REQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // a write seen at the edge where it lands
    wire wr = PSEL && PENABLE && PREADY && PWRITE;

    ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    unmapped_error_a: assert property (
        PSEL && !PENABLE && PADDR > 8'h1c
        |=> PSLVERR) else $error("no error on unmapped");
    error_zero_data_a: assert property (
        PSLVERR |-> PREADY && PRDATA == 0)
        else $error("error without ready or with data");
    latch_to_pin_a: assert property (wr && PADDR == 8'h04
        |-> ##2 PAR_OUT[4:0] == $past(PWDATA[4:0], 2))
        else $error("pin data not from latch");
    dir_to_enable_a: assert property (wr && PADDR == 8'h08
        |-> ##2 (PAR_OE == ~$past(PWDATA[7:0], 2) || SLAVE_PORT_ACTIVE))
        else $error("enable not inverse of direction");
    slave_floats_a: assert property (SLAVE_PORT_ACTIVE
        && $past(SLAVE_PORT_ACTIVE) |-> PAR_OE == 8'h00)
        else $error("pins driven in slave mode");
    clear_off_quiet_a: assert property (!MASTER_CLEAR_ENABLE_CFG [*4]
        |=> !MASTER_CLEAR_REQ) else $error("clear with strap off");
endmodule

bind port_io port_io_assertions chk (.MCLK(MCLK), .RESET_N(RESET_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PAR_OUT(PAR_OUT), .PAR_OE(PAR_OE), .SLAVE_PORT_ACTIVE(SLAVE_PORT_ACTIVE),
    .MASTER_CLEAR_ENABLE_CFG(MASTER_CLEAR_ENABLE_CFG),
    .MASTER_CLEAR_REQ(MASTER_CLEAR_REQ));

/* File: dv/pin_world.sv */
// outside circuitry on the port pins, resolving each wire level
`timescale 1ns/1ps
module pin_world (
    // drivers of the port block
    input wire [7:0] par_out,
    input wire [7:0] par_oe,
    input wire [2:0] small_out,
    input wire [2:0] small_oe,
    // levels the outside drives
    input wire [7:0] ext_par,
    input wire [3:0] ext_small,
    // resolved wire levels
    output wire [7:0] par_in,
    output wire [3:0] small_in
);
    // a driven pin shows the block's level, a floating one ours
    assign par_in = (par_oe & par_out) | (~par_oe & ext_par);
    // fourth pin has no driver, so it is always ours
    assign small_in = {ext_small[3],
        (small_oe & small_out) | (~small_oe & ext_small[2:0])};
endmodule

/* File: dv/eight_bit_and_four_bit_io_ports_bench.sv */
// self-checking bench of the two i/o ports
`timescale 1ns/1ps
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin \
    n_fail = n_fail + 1; $display("unexpected at %0t: %h not %h", \
    $time, a, b); end end
module eight_bit_and_four_bit_io_ports_bench;
    reg MCLK = 0;
    reg RESET_N = 0;
    reg PSEL = 0;
    reg PENABLE = 0;
    reg PWRITE = 0;
    reg [7:0] PADDR = 8'h00;
    reg [31:0] PWDATA = 32'h0;
    reg mce = 0;
    reg spp = 1;
    reg [2:0] pwm = 3'h0;
    reg [2:0] sst = 3'h0;
    reg [7:0] ext_par = 8'h00;
    reg [3:0] ext_small = 4'h7;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, SPA, MCR;
    wire [7:0] PAR_IN, PAR_OUT, PAR_OE;
    wire [3:0] SMALL_IN;
    wire [2:0] SMALL_OUT, SMALL_OE;
    integer n_fail = 0, checks = 0, i, m;
    reg [7:0] d, l, p, r;
    reg err;

    port_io DUT (.MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .PAR_IN(PAR_IN), .PAR_OUT(PAR_OUT), .PAR_OE(PAR_OE),
        .SMALL_IN(SMALL_IN), .SMALL_OUT(SMALL_OUT), .SMALL_OE(SMALL_OE),
        .MASTER_CLEAR_ENABLE_CFG(mce), .SMALL_PORT_PRESENT(spp),
        .PWM_OUT_B(pwm[2]), .PWM_OUT_C(pwm[1]), .PWM_OUT_D(pwm[0]),
        .IN_BUFFER_FULL(sst[2]), .OUT_BUFFER_FULL(sst[1]),
        .IN_OVERFLOW_SET(sst[0]), .SLAVE_PORT_ACTIVE(SPA),
        .MASTER_CLEAR_REQ(MCR));
    pin_world pins (.par_out(PAR_OUT), .par_oe(PAR_OE),
        .small_out(SMALL_OUT), .small_oe(SMALL_OE), .ext_par(ext_par),
        .ext_small(ext_small), .par_in(PAR_IN), .small_in(SMALL_IN));

    // 40 MHz clock
    initial forever #12.5 MCLK = ~MCLK;

    // pins register: inputs show the wire, outputs the latch
    function [7:0] pins_exp(input [7:0] dir, lat, ext);
        pins_exp = (dir & ext) | (~dir & lat);
    endfunction

    // bits 7:5 under pwm, b on 5 once dual, c and d once quad
    function [2:0] hi_exp(input [1:0] md, input [2:0] lat, bcd);
        hi_exp = {md[0] ? bcd[0] : lat[2], md[0] ? bcd[1] : lat[1],
            md != 2'h0 ? bcd[2] : lat[0]};
    endfunction

    // one apb transfer, held until ready; leaves an idle edge after
    task bus(input w, input [7:0] a, input [7:0] wd);
        integer n;
        begin
            PSEL <= 1'b1;
            PWRITE <= w;
            PADDR <= a;
            PWDATA <= {24'h0, wd};
            @(posedge MCLK);
            PENABLE <= 1'b1;
            n = 0;
            // look at ready inside the cycle, never at the racing edge
            #1;
            while (PREADY !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge MCLK);
                #1;
            end
            if (n == 20) n_fail = n_fail + 1;
            r = PRDATA[7:0];
            err = PSLVERR;
            // completing edge; only then is the request released
            @(posedge MCLK);
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
            @(posedge MCLK);
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #(25 * 5000);
        n_fail = n_fail + 1;
        stop_test;
    end

    initial begin
        r = $urandom(8471);
        repeat (4) @(posedge MCLK);
        RESET_N <= 1'b1;
        @(posedge MCLK);
        bus(0, 8'h08, 0); `CHK(r, 8'hff)
        bus(0, 8'h0c, 0); `CHK(r, 8'h07)
        bus(0, 8'h10, 0); `CHK(r, 8'h00)
        // random direction, latch and wire levels, all-out and all-in first
        for (i = 0; i < 8; i = i + 1) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : $urandom;
            l = $urandom;
            p = $urandom;
            bus(1, 8'h08, d);
            bus(1, 8'h04, l);
            ext_par <= p;
            repeat (4) @(posedge MCLK);
            `CHK(PAR_OE, ~d)
            `CHK(PAR_OUT[4:0], l[4:0])
            bus(0, 8'h04, 0); `CHK(r, l)
            bus(0, 8'h00, 0); `CHK(r, pins_exp(d, l, p))
            bus(1, 8'h00, p);
            bus(0, 8'h04, 0); `CHK(r, p)
        end
        // slave mode with control pins in, analog off; reserved bit reads 0
        bus(1, 8'h08, 8'h00);
        bus(1, 8'h1c, 8'h0a);
        bus(1, 8'h0c, 8'hff);
        bus(0, 8'h0c, 0); `CHK(r, 8'h37)
        sst <= 3'h6;
        bus(0, 8'h0c, 0); `CHK(r, 8'hf7)
        sst <= 3'h0;
        for (m = 0; m < 4; m = m + 1) begin
            bus(1, 8'h18, {m[1:0], 6'h0c});
            pwm <= $urandom;
            repeat (3) @(posedge MCLK);
            `CHK(SPA, m == 0)
            `CHK(PAR_OE, {8{m != 0}})
            `CHK(PAR_OUT[7:5], hi_exp(m[1:0], p[7:5], pwm))
        end
        bus(1, 8'h18, 8'h00);
        bus(1, 8'h0c, 8'h00);
        repeat (2) @(posedge MCLK);
        `CHK(SPA, 1'b0)
        // small port: latch, drivers, fourth pin, analog, absent variant
        bus(1, 8'h14, 8'h05);
        bus(0, 8'h14, 0); `CHK(r, 8'h05)
        ext_small <= 4'h8;
        repeat (4) @(posedge MCLK);
        `CHK(SMALL_OE, 3'h7)
        bus(0, 8'h10, 0); `CHK(r, 8'h0d)
        spp <= 1'b0;
        repeat (4) @(posedge MCLK);
        bus(0, 8'h10, 0); `CHK(r, 8'h00)
        spp <= 1'b1;
        bus(1, 8'h1c, 8'h00);
        bus(0, 8'h10, 0); `CHK(r, 8'h08)
        `CHK(SMALL_OE, 3'h7)
        mce <= 1'b1;
        ext_small <= 4'h0;
        repeat (4) @(posedge MCLK);
        `CHK(MCR, 1'b1)
        bus(0, 8'h10, 0); `CHK(r, 8'h00)
        bus(0, 8'h20, 0); `CHK(err, 1'b1)
        stop_test;
    end
endmodule
